// ===== dv/acz_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "acz_cfg.svh"
module acz_checker #(
    parameter int CHANS = 8,
    parameter int RES_W = 10,
    parameter int CONV_CYC = `ACZ_CONV_CYC
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // front end
    input wire logic CONVERTER_ENABLE,
    input wire logic INTERNAL_REFERENCE_ENABLE,
    input wire logic [CHANS-1:0] ANALOG_CHANNEL_SELECT,
    input wire logic SAMPLE_STROBE,
    input wire logic [RES_W-1:0] DAC_TRIAL,
    input wire logic COMPARATOR_HI,
    // interrupt
    input wire logic IRQ
);
    // first trial comes one step after the start
    localparam int STEP = (CONV_CYC / RES_W > 0) ? CONV_CYC / RES_W : 1;
    localparam int TRIAL_MAX = STEP + 2;
    logic acc, ctl_wr, ctl_rd, irq_off;
    assign acc = PSEL && PENABLE;
    assign ctl_wr = acc && PWRITE && PADDR == `ACZ_CTL0_ADDR;
    assign ctl_rd = acc && !PWRITE && PADDR == `ACZ_CTL0_ADDR;
    // status one-clear or mask-clear both drop the request
    assign irq_off = acc && PWRITE && ((PADDR == `ACZ_STAT_ADDR && PWDATA[0])
        || (PADDR == `ACZ_MASK_ADDR && !PWDATA[0]));
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    chan_onehot_a: assert property (
        $onehot0(ANALOG_CHANNEL_SELECT)) else $error("channel not one-hot");
    chan_decode_a: assert property (
        ctl_wr |-> ##2 ANALOG_CHANNEL_SELECT == ({{(CHANS-1){1'b0}}, 1'b1}
        << $past(PWDATA[2:0], 2))) else $error("channel decode wrong");
    enable_copy_a: assert property (
        ctl_wr |-> ##2 CONVERTER_ENABLE == $past(PWDATA[4], 2))
        else $error("enable copy wrong");
    ref_copy_a: assert property (
        ctl_wr |-> ##2 INTERNAL_REFERENCE_ENABLE == $past(PWDATA[5], 2))
        else $error("reference copy wrong");
    start_trials_a: assert property (
        ctl_wr && PWDATA[7] && PWDATA[4] |-> ##[1:TRIAL_MAX] SAMPLE_STROBE)
        else $error("start gave no trial");
    powerdown_stop_a: assert property (
        ctl_wr && !PWDATA[4] |-> ##3 !SAMPLE_STROBE [*4])
        else $error("trials while powered down");
    irq_clear_a: assert property (
        irq_off |-> ##2 !IRQ) else $error("interrupt not cleared");
    rsvd_read_a: assert property (
        ctl_rd |-> PRDATA[31:8] == 24'h0 && !PRDATA[6] && !PRDATA[3])
        else $error("reserved bits read one");
    trial_code_a: assert property (
        SAMPLE_STROBE |-> DAC_TRIAL != '0) else $error("empty trial code");
    reset_quiet_a: assert property (disable iff (1'b0)
        !RST_N |=> !IRQ && !CONVERTER_ENABLE && !SAMPLE_STROBE)
        else $error("outputs not cleared by reset");
    cover property (ctl_wr && PWDATA[7] && PWDATA[4]);
    cover property ($rose(IRQ));
    cover property (acc && PSLVERR);
endmodule : acz_checker

bind acz_top acz_checker #(.CHANS(CHANS), .RES_W(RES_W),
    .CONV_CYC(CONV_CYC)) u_chk (
    .REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .CONVERTER_ENABLE, .INTERNAL_REFERENCE_ENABLE,
    .ANALOG_CHANNEL_SELECT, .SAMPLE_STROBE, .DAC_TRIAL, .COMPARATOR_HI, .IRQ);
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "acz_cfg.svh"
module tb;
    localparam logic [11:0] a_ctl = `ACZ_CTL0_ADDR;
    localparam logic [11:0] a_dat = `ACZ_DATA_ADDR;
    localparam logic [11:0] a_st = `ACZ_STAT_ADDR;
    localparam logic [11:0] a_msk = `ACZ_MASK_ADDR;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic cmp_hi = 0, pready, pslverr, conv_en, iref_en, strobe, irq, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, v, seed = 32'h9d90;
    logic [7:0] chan_sel;
    logic [9:0] trial;
    int failures = 0, n_checks = 0;
    acz_top #(.CONV_CYC(40)) dut (.REF_CLK(ref_clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CONVERTER_ENABLE(conv_en),
        .INTERNAL_REFERENCE_ENABLE(iref_en), .ANALOG_CHANNEL_SELECT(chan_sel),
        .SAMPLE_STROBE(strobe), .DAC_TRIAL(trial), .COMPARATOR_HI(cmp_hi),
        .IRQ(irq));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    task automatic convert(input logic lvl, input logic [2:0] ch);
        @(posedge ref_clk);
        cmp_hi <= lvl;
        apb(1'b1, a_ctl, 32'h90 | ch);
        rd_chk(a_ctl, 32'h90 | ch);
        apb(1'b1, a_ctl, 32'h10 | ch);
        apb(1'b1, a_ctl, 32'h90 | ch);
        rd_chk(a_ctl, 32'h90 | ch);
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge ref_clk);
        chk(irq, 1);
        rd_chk(a_ctl, 32'h10 | ch);
        rd_chk(a_dat, lvl ? 32'h3ff : 32'h0);
        rd_chk(a_st, 32'h1);
        apb(1'b1, a_st, 32'h1);
        repeat (2) @(negedge ref_clk);
        chk(irq, 0);
    endtask : convert
    initial begin
        #200000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(a_ctl, 32'h0);
        rd_chk(a_msk, 32'h0);
        for (int ch = 0; ch < 8; ch++) begin
            v = (xs() & 32'h20) | 32'h10 | ch;
            apb(1'b1, a_ctl, v);
            repeat (2) @(negedge ref_clk);
            chk(chan_sel, 8'h1 << ch);
            chk({conv_en, iref_en}, {1'b1, v[5]});
            rd_chk(a_ctl, v & 32'h37);
        end
        apb(1'b1, a_msk, 32'h1);
        v = xs();
        convert(1'b1, v[2:0]);
        convert(1'b0, 3'd7);
        // masked completion: status set, no request
        apb(1'b1, a_msk, 32'h0);
        apb(1'b1, a_ctl, 32'h91);
        repeat (60) @(negedge ref_clk);
        chk(irq, 0);
        rd_chk(a_st, 32'h1);
        rd_chk(a_ctl, 32'h11);
        apb(1'b1, a_st, 32'h1);
        apb(1'b1, a_msk, 32'h1);
        apb(1'b1, a_ctl, 32'h80);
        rd_chk(a_ctl, 32'h0);
        apb(1'b1, a_ctl, 32'h95);
        repeat (8) @(posedge ref_clk);
        apb(1'b1, a_ctl, 32'h0);
        repeat (60) @(negedge ref_clk);
        rd_chk(a_ctl, 32'h0);
        chk(irq, 0);
        rd_chk(a_st, 32'h0);
        apb(1'b0, 12'hf80, 32'h0);
        chk(err, 1);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ===== rtl/acz_cfg.svh
`ifndef ACZ_CFG_SVH
`define ACZ_CFG_SVH

// register byte addresses (apb)
`define ACZ_CTL0_ADDR 12'hf70
`define ACZ_DATA_ADDR 12'hf74
`define ACZ_STAT_ADDR 12'hf78
`define ACZ_MASK_ADDR 12'hf7c

// control register zero fields
`define ACZ_START_BIT 7
`define ACZ_RSVD6_BIT 6
`define ACZ_INTERNAL_REFERENCE_ENABLE_BIT 5
`define ACZ_CONVERTER_ENABLE_BIT 4
`define ACZ_RSVD3_BIT 3
`define ACZ_CHAN_MSB 2
`define ACZ_CHAN_LSB 0

// status / mask fields
`define ACZ_DONE_BIT 0

// reset values
`define ACZ_CTL0_RST 8'h00
`define ACZ_MASK_RST 1'b0

// timing: conversion time in ns as printed, and its cycle count at 50 MHz
`define ACZ_CONV_NS 11900
`define ACZ_CLK_NS 20
`define ACZ_CONV_CYC ((`ACZ_CONV_NS + `ACZ_CLK_NS - 1) / `ACZ_CLK_NS)

`endif

// ===== rtl/acz_pkg.sv
`default_nettype none
package acz_pkg;

    typedef enum {
        ACZ_IDLE,
        ACZ_CONV
    } acz_state_e;

    typedef struct packed {
        logic start;
        logic int_ref_en;
        logic conv_en;
        logic [2:0] chan;
    } acz_ctl_s;

    typedef struct packed {
        logic valid;
        logic [9:0] data;
    } acz_result_s;

endpackage : acz_pkg

`default_nettype wire

// ===== rtl/acz_sar.sv
`timescale 1ns/1ps
`default_nettype none
`include "acz_cfg.svh"

module acz_sar
    import acz_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CONV_CYC = `ACZ_CONV_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic go,
    input wire logic enable,
    // comparator from the analog front end
    input wire logic cmp_hi,
    // status
    output logic busy,
    output logic trial_stb,
    output logic [RES_W-1:0] trial,
    output logic done,
    output logic [RES_W-1:0] result
);
    localparam int STEP = (CONV_CYC / RES_W > 0) ? CONV_CYC / RES_W : 1;
    localparam int CW = $clog2(STEP + 1);
    localparam int BW = $clog2(RES_W + 1);

    acz_state_e state_r;
    logic [CW-1:0] cnt_r;
    logic [BW-1:0] bit_r;
    logic [RES_W-1:0] sar_r;
    logic [RES_W-1:0] mask;
    logic step_end;

    assign mask = {{(RES_W-1){1'b0}}, 1'b1} << bit_r;
    assign step_end = (cnt_r == CW'(STEP - 1));
    assign busy = (state_r == ACZ_CONV);
    assign trial = sar_r | mask;
    assign trial_stb = busy && step_end;

    // sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ACZ_IDLE;
        end else begin
            case (state_r)
                ACZ_IDLE: begin
                    if (go && enable) begin
                        state_r <= ACZ_CONV;
                    end
                end
                ACZ_CONV: begin
                    if (!enable || (step_end && bit_r == '0)) begin
                        state_r <= ACZ_IDLE;
                    end
                end
                default: state_r <= ACZ_IDLE;
            endcase
        end
    end

    // step timer and bit pointer
    always_ff @(posedge clk) begin
        if (!rst_n || !busy) begin
            cnt_r <= '0;
            bit_r <= BW'(RES_W - 1);
        end else if (step_end) begin
            cnt_r <= '0;
            bit_r <= bit_r - 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // successive approximation, one bit per step
    always_ff @(posedge clk) begin
        if (!rst_n || (!busy && go)) begin
            sar_r <= '0;
        end else if (trial_stb) begin
            sar_r <= cmp_hi ? trial : sar_r;
        end
    end

    // completion pulse with result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            result <= '0;
        end else begin
            done <= busy && enable && step_end && bit_r == '0;
            if (busy && enable && step_end && bit_r == '0) begin
                result <= cmp_hi ? trial : sar_r;
            end
        end
    end

endmodule : acz_sar

`default_nettype wire

// ===== rtl/acz_top.sv
// Behaviour
// - writing one to bit 7 starts conversion when idle and with bit 4 set
// - writing zero to bit 7 does nothing
// - bit 7 reads one while converting
// - bit 5 enables internal reference output
// - bit 4 powers converter up
// - bits 2:0 select one of eight inputs
// - each conversion yields ten-bit result
// - completion raises an interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "acz_cfg.svh"

module acz_top
    import acz_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CHANS = 8,
    parameter int CONV_CYC = `ACZ_CONV_CYC
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog front end control
    output logic CONVERTER_ENABLE,
    output logic INTERNAL_REFERENCE_ENABLE,
    output logic [CHANS-1:0] ANALOG_CHANNEL_SELECT,
    output logic SAMPLE_STROBE,
    output logic [RES_W-1:0] DAC_TRIAL,
    input wire logic COMPARATOR_HI,
    // interrupt
    output logic IRQ
);
    acz_ctl_s ctl_r;
    acz_result_s res;
    logic busy, done_pls, trial_stb;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] data_r;
    logic stat_r, mask_r;
    logic cmp_s1_r, cmp_s2_r, cmp_s3_r, cmp_r;
    logic wr_acc, rd_hit;
    logic hit_ctl, hit_dat, hit_st, hit_msk;
    logic wr_ctl, wr_st, wr_msk;
    logic en_now;
    logic start_req;
    logic [31:0] ctl_word;

    assign PREADY = 1'b1;
    assign wr_acc = PSEL && PENABLE && PWRITE;

    // address decode
    assign hit_ctl = (PADDR == `ACZ_CTL0_ADDR);
    assign hit_dat = (PADDR == `ACZ_DATA_ADDR);
    assign hit_st = (PADDR == `ACZ_STAT_ADDR);
    assign hit_msk = (PADDR == `ACZ_MASK_ADDR);
    assign rd_hit = hit_ctl || hit_dat || hit_st || hit_msk;
    assign PSLVERR = PSEL && PENABLE && !rd_hit;

    assign wr_ctl = wr_acc && hit_ctl;
    assign wr_st = wr_acc && hit_st;
    assign wr_msk = wr_acc && hit_msk;

    // an enable written in the same transfer already counts
    assign en_now = wr_ctl ? PWDATA[`ACZ_CONVERTER_ENABLE_BIT]
        : ctl_r.conv_en;

    // start only on a one written to bit 7; a zero is ignored
    assign start_req = wr_ctl && PWDATA[`ACZ_START_BIT] && en_now
        && !busy;

    // control fields and busy bit; reserved bits kept at zero
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctl_r <= '0;
        end else begin
            if (wr_ctl) begin
                ctl_r.int_ref_en <= PWDATA[`ACZ_INTERNAL_REFERENCE_ENABLE_BIT];
                ctl_r.conv_en <= PWDATA[`ACZ_CONVERTER_ENABLE_BIT];
                ctl_r.chan <= PWDATA[`ACZ_CHAN_MSB:`ACZ_CHAN_LSB];
            end
            if (start_req) begin
                ctl_r.start <= 1'b1;
            end else if (done_pls || !busy) begin
                ctl_r.start <= 1'b0;
            end
        end
    end

    // readback word; reserved bits read zero
    always_comb begin
        ctl_word = 32'h00000000;
        ctl_word[`ACZ_START_BIT] = ctl_r.start;
        ctl_word[`ACZ_INTERNAL_REFERENCE_ENABLE_BIT] = ctl_r.int_ref_en;
        ctl_word[`ACZ_CONVERTER_ENABLE_BIT] = ctl_r.conv_en;
        ctl_word[`ACZ_CHAN_MSB:`ACZ_CHAN_LSB] = ctl_r.chan;
    end

    // comparator comes from analog domain
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
            cmp_r <= 1'b0;
        end else begin
            cmp_s1_r <= COMPARATOR_HI;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            if (cmp_s2_r == cmp_s3_r) begin
                cmp_r <= cmp_s3_r;
            end
        end
    end

    acz_sar #(
        .RES_W(RES_W),
        .CONV_CYC(CONV_CYC)
    ) u_sar (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .go(start_req),
        .enable(en_now),
        .cmp_hi(cmp_r),
        .busy(busy),
        .trial_stb(trial_stb),
        .trial(trial),
        .done(done_pls),
        .result(res.data)
    );
    assign res.valid = done_pls;

    // result register, ten bits
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            data_r <= '0;
        end else if (res.valid) begin
            data_r <= res.data;
        end
    end

    // sticky done flag; new event wins over write-one clear
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            stat_r <= 1'b0;
        end else if (done_pls) begin
            stat_r <= 1'b1;
        end else if (wr_st && PWDATA[`ACZ_DONE_BIT]) begin
            stat_r <= 1'b0;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mask_r <= `ACZ_MASK_RST;
        end else if (wr_msk) begin
            mask_r <= PWDATA[`ACZ_DONE_BIT];
        end
    end

    // read data registered in setup phase
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE) begin
            case (PADDR)
                `ACZ_CTL0_ADDR: PRDATA <= ctl_word;
                `ACZ_DATA_ADDR: PRDATA <= {{(32-RES_W){1'b0}}, data_r};
                `ACZ_STAT_ADDR: PRDATA <= {31'h0, stat_r};
                `ACZ_MASK_ADDR: PRDATA <= {31'h0, mask_r};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

    // interrupt level: pending event under mask
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= (stat_r || done_pls) && mask_r;
        end
    end

    // power and reference controls
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CONVERTER_ENABLE <= 1'b0;
            INTERNAL_REFERENCE_ENABLE <= 1'b0;
        end else begin
            CONVERTER_ENABLE <= ctl_r.conv_en;
            INTERNAL_REFERENCE_ENABLE <= ctl_r.int_ref_en;
        end
    end

    // one-hot input select
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ANALOG_CHANNEL_SELECT <= '0;
        end else begin
            ANALOG_CHANNEL_SELECT <= CHANS'(1) << ctl_r.chan;
        end
    end

    // trial strobe and code towards the comparator
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            SAMPLE_STROBE <= 1'b0;
            DAC_TRIAL <= '0;
        end else begin
            SAMPLE_STROBE <= trial_stb;
            DAC_TRIAL <= trial;
        end
    end

endmodule : acz_top

`default_nettype wire
